// ---- core/pmisr_defs.vh ----
`ifndef PMISR_DEFS_VH
`define PMISR_DEFS_VH
// Register offsets (7-bit register address).
`define PMISR_ADDR_W 7
`define PMISR_OFF_SAMPLE 7'h2a
`define PMISR_OFF_POWER 7'h2c
`define PMISR_OFF_FLAGS 7'h2d
`define PMISR_OFF_KEY 7'h2f
`define PMISR_OFF_STATE 7'h30
// Status word bit positions.
`define PMISR_BIT_ZC 0
`define PMISR_BIT_OC 1
`define PMISR_BIT_OCL 2
`define PMISR_BIT_OV 3
`define PMISR_BIT_UV 4
`define PMISR_BIT_CUST 0
// Customer unlock value.
`define PMISR_UNLOCK_KEY 32'h4f70656e
`define PMISR_KEY_RESET 32'h00000000
`define PMISR_ZERO32 32'h00000000
// Fraction bits of the Q1.15 sample format.
`define PMISR_FRAC 15
// Output selection codes.
`define PMISR_SEL_ZC 2'h0
`define PMISR_SEL_OC 2'h1
`define PMISR_SEL_VOLT 2'h2
`define PMISR_SEL_OCL 2'h3
`endif

// ---- core/pmisr_sync.v ----
`timescale 1ns/1ps
`include "pmisr_defs.vh"
module pmisr_sync #(
    parameter W = 4
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    // A bit is taken only once the second and third stages agree.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));
        end
    end
endmodule // pmisr_sync

// ---- core/pmisr_regs.v ----
// Operation
// RULE1 - The raw voltage sample reads in bits 15:0 of the sample register as signed Q1.15.
// RULE2 - The raw current sample reads in bits 31:16 of the sample register as signed Q1.15.
// RULE3 - Instantaneous power is voltage times current, placed in bits 15:0 as signed Q1.15.
// RULE4 - Status bits are zero-crossing 0, live fault 1, latched fault 2, overvoltage 3, undervoltage 4.
// RULE5 - The zero-crossing flag is always reported, shaped by the half-cycle and square-wave settings.
// RULE6 - The live overcurrent flag is always reported and is set only while the fault is present.
// RULE7 - The latched overcurrent flag sets on the first fault and holds until software writes a 1.
// RULE8 - Overvoltage and undervoltage flags are always reported, each set only while its fault holds.
// RULE9 - Software writes the 32-bit customer value into the key register to gain customer access.
// RULE10 - Bit 0 of the unlock state register reads 1 in customer mode and 0 otherwise.
// RULE11 - Customer mode is set only by the exact unlock value and cleared by any other value.
// RULE12 - Each pin selection picks the flags on its output pin and applies only in the I2C mode.
`timescale 1ns/1ps
`include "pmisr_defs.vh"
module pmisr_regs #(
    parameter SMP_W = 16
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire [SMP_W-1:0] vsample_in,
    input wire [SMP_W-1:0] isample_in,
    input wire sample_valid_in,
    input wire zc_event_in,
    input wire oc_fault_in,
    input wire ov_fault_in,
    input wire uv_fault_in,
    input wire halfcycle_en_in,
    input wire squarewave_en_in,
    input wire i2c_mode_in,
    input wire [1:0] pin0_sel_in,
    input wire [1:0] pin1_sel_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [`PMISR_ADDR_W-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    output reg reg_rvalid_out,
    output reg customer_mode_out,
    output reg pin0_out,
    output reg pin1_out
);
    reg [SMP_W-1:0] v_reg;
    reg [SMP_W-1:0] i_reg;
    reg [SMP_W-1:0] p_reg;
    reg [31:0] key_reg;
    reg zc_reg;
    reg oc_latch_reg;
    wire [3:0] flags_sync;
    wire oc_now;
    wire ov_now;
    wire uv_now;
    wire zc_raw;
    wire zc_rise;
    reg zc_prev_reg;
    wire [2*SMP_W-1:0] prod;
    wire [4:0] status;

    // Fault and event inputs come from analogue comparators, so they are synchronised.
    pmisr_sync #(.W(4)) u_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .async_in({uv_fault_in, ov_fault_in, oc_fault_in, zc_event_in}),
        .sync_out(flags_sync)
    );
    assign zc_raw = flags_sync[0];
    assign oc_now = flags_sync[1];
    assign ov_now = flags_sync[2];
    assign uv_now = flags_sync[3];
    assign zc_rise = zc_raw & ~zc_prev_reg;

    // Full product is Q2.30; shifting by the fraction width keeps Q1.15.
    assign prod = $signed(v_reg) * $signed(i_reg);

    // Voltage and current are captured together; power is recomputed every cycle from the held pair, so it follows one cycle later.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            v_reg <= {SMP_W{1'b0}};
            i_reg <= {SMP_W{1'b0}};
            p_reg <= {SMP_W{1'b0}};
        end else begin
            if (sample_valid_in) begin
                v_reg <= vsample_in; // [RULE1]
                i_reg <= isample_in; // [RULE2]
            end
            p_reg <= prod[`PMISR_FRAC+SMP_W-1:`PMISR_FRAC]; // [RULE3]
        end
    end

    // Zero-crossing shaping: pulse per crossing, optionally every half-cycle, or a square wave.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            zc_prev_reg <= 1'b0;
            zc_reg <= 1'b0;
        end else begin
            zc_prev_reg <= zc_raw;
            if (squarewave_en_in) begin
                zc_reg <= zc_raw; // [RULE5]
            end else if (halfcycle_en_in) begin
                zc_reg <= zc_raw ^ zc_prev_reg; // [RULE5]
            end else begin
                zc_reg <= zc_rise; // [RULE5]
            end
        end
    end

    // Latched fault: a new fault in the clearing cycle wins over the clear.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            oc_latch_reg <= 1'b0;
        end else if (oc_now) begin
            oc_latch_reg <= 1'b1; // [RULE7]
        end else if (reg_wr_in && reg_addr_in == `PMISR_OFF_FLAGS &&
                     reg_wdata_in[`PMISR_BIT_OCL]) begin
            oc_latch_reg <= 1'b0; // [RULE7]
        end
    end

    // Key register and customer mode; the mode follows every key write.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            key_reg <= `PMISR_KEY_RESET;
            customer_mode_out <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == `PMISR_OFF_KEY) begin
            key_reg <= reg_wdata_in; // [RULE9]
            customer_mode_out <= (reg_wdata_in == `PMISR_UNLOCK_KEY); // [RULE11]
        end
    end

    assign status = {uv_now, ov_now, oc_latch_reg, oc_now, zc_reg}; // [RULE4] [RULE6] [RULE8]

    function pin_pick;
        input [1:0] sel;
        input [4:0] st;
        begin
            if (sel == `PMISR_SEL_ZC) begin
                pin_pick = st[`PMISR_BIT_ZC];
            end else if (sel == `PMISR_SEL_OC) begin
                pin_pick = st[`PMISR_BIT_OC];
            end else if (sel == `PMISR_SEL_VOLT) begin
                pin_pick = st[`PMISR_BIT_OV] | st[`PMISR_BIT_UV];
            end else begin
                pin_pick = st[`PMISR_BIT_OCL];
            end
        end
    endfunction

    // Pins are only meaningful in I2C mode; in SPI mode they serve the bus and stay low here.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            pin0_out <= 1'b0;
            pin1_out <= 1'b0;
        end else begin
            pin0_out <= i2c_mode_in & pin_pick(pin0_sel_in, status); // [RULE12]
            pin1_out <= i2c_mode_in & pin_pick(pin1_sel_in, status); // [RULE12]
        end
    end

    // Read port: data one cycle after the read strobe; unmapped addresses read zero.
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= `PMISR_ZERO32;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                if (reg_addr_in == `PMISR_OFF_SAMPLE) begin
                    reg_rdata_out <= {i_reg, v_reg}; // [RULE1] [RULE2]
                end else if (reg_addr_in == `PMISR_OFF_POWER) begin
                    reg_rdata_out <= {{(32-SMP_W){1'b0}}, p_reg}; // [RULE3]
                end else if (reg_addr_in == `PMISR_OFF_FLAGS) begin
                    reg_rdata_out <= {27'h0000000, status}; // [RULE4]
                end else if (reg_addr_in == `PMISR_OFF_KEY) begin
                    reg_rdata_out <= key_reg;
                end else if (reg_addr_in == `PMISR_OFF_STATE) begin
                    reg_rdata_out <= {31'h00000000, customer_mode_out}; // [RULE10]
                end else begin
                    reg_rdata_out <= `PMISR_ZERO32;
                end
            end
        end
    end
endmodule // pmisr_regs

// ---- test/pmisr_regs_properties.sv ----
`timescale 1ns/1ps
`include "pmisr_defs.vh"
module pmisr_regs_properties (
    input wire ref_clk_in,
    input wire srst_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [`PMISR_ADDR_W-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    input wire reg_rvalid_out,
    input wire customer_mode_out,
    input wire i2c_mode_in,
    input wire pin0_out,
    input wire pin1_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire key_wr = reg_wr_in && reg_addr_in == `PMISR_OFF_KEY;
    wire key_ok = reg_wdata_in == `PMISR_UNLOCK_KEY;
    wire rd_state = reg_rd_in && reg_addr_in == `PMISR_OFF_STATE;
    chk_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    chk_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("answer without read");
    chk_key_sets: assert property (key_wr && key_ok |=> customer_mode_out)
        else $error("mode not set");
    chk_key_clears: assert property (key_wr && !key_ok |=> !customer_mode_out)
        else $error("mode not cleared");
    chk_mode_holds: assert property (!key_wr |=> $stable(customer_mode_out))
        else $error("mode moved");
    chk_state_read: assert property (rd_state |=> reg_rdata_out == {31'h0, $past(customer_mode_out)})
        else $error("state read wrong");
    chk_power_upper: assert property (reg_rd_in && reg_addr_in == `PMISR_OFF_POWER
        |=> reg_rdata_out[31:16] == 16'h0) else $error("power upper set");
    chk_pins_idle: assert property (!i2c_mode_in [*2] |=> !pin0_out && !pin1_out)
        else $error("pin active");
    cover property (key_wr && key_ok);
    cover property (reg_rd_in && reg_addr_in == `PMISR_OFF_FLAGS);
    cover property (pin0_out && pin1_out);
endmodule // pmisr_regs_properties
bind pmisr_regs pmisr_regs_properties u_chk (.*);

// ---- test/pmisr_host_model.sv ----
`timescale 1ns/1ps
`include "pmisr_defs.vh"
module pmisr_host_model (
    input wire ref_clk_in,
    output reg reg_wr_out = 1'b0,
    output reg reg_rd_out = 1'b0,
    output reg [`PMISR_ADDR_W-1:0] reg_addr_out = 7'h00,
    output reg [31:0] reg_wdata_out = 32'h00000000
);
    task xfer(input logic wr, input logic [6:0] ad, input logic [31:0] d);
        @(posedge ref_clk_in);
        #1;
        reg_wr_out = wr;
        reg_rd_out = !wr;
        reg_addr_out = ad;
        reg_wdata_out = d;
        @(posedge ref_clk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        // Released lines carry the inverse so nothing can lean on stale values.
        reg_addr_out = ~ad;
        reg_wdata_out = ~d;
    endtask
endmodule // pmisr_host_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "pmisr_defs.vh"
module tb_top;
    reg ref_clk_in = 1'b0;
    reg srst_in = 1'b1;
    reg [15:0] vsample_in = 16'h0, isample_in = 16'h0, lfsr = 16'h002d;
    reg sample_valid_in = 0, zc_event_in = 0, oc_fault_in = 0, ov_fault_in = 0, uv_fault_in = 0;
    reg halfcycle_en_in = 0, squarewave_en_in = 0, i2c_mode_in = 0;
    reg [1:0] pin0_sel_in = `PMISR_SEL_OC, pin1_sel_in = `PMISR_SEL_OCL;
    wire reg_wr_in, reg_rd_in, reg_rvalid_out, customer_mode_out, pin0_out, pin1_out;
    wire [6:0] reg_addr_in;
    wire [31:0] reg_wdata_in, reg_rdata_out;
    reg [31:0] expq[$];
    reg signed [31:0] pr;
    integer err_count = 0, checks_done = 0, n;
    always #12.5 ref_clk_in = ~ref_clk_in;
    pmisr_regs u_dut (.*);
    pmisr_host_model u_host (.ref_clk_in(ref_clk_in), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
    function [15:0] nx(input [15:0] x);
        nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rdx(input [6:0] ad, input [31:0] ex);
        expq.push_back(ex);
        u_host.xfer(1'b0, ad, 32'h0);
    endtask
    task wt(input integer k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    always @(posedge ref_clk_in) begin
        if (reg_rvalid_out === 1'b1) begin
            if (expq.size() == 0) check(reg_rdata_out, 32'hxxxxxxxx);
            else check(reg_rdata_out, expq.pop_front());
        end
    end
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        wt(4);
        srst_in = 1'b0;
        u_host.xfer(1'b1, `PMISR_OFF_KEY, 32'h4f70656f);
        rdx(`PMISR_OFF_STATE, 32'h0);
        u_host.xfer(1'b1, `PMISR_OFF_KEY, `PMISR_UNLOCK_KEY);
        rdx(`PMISR_OFF_STATE, 32'h1);
        rdx(`PMISR_OFF_KEY, `PMISR_UNLOCK_KEY);
        check({31'h0, customer_mode_out}, 32'h1);
        u_host.xfer(1'b1, `PMISR_OFF_STATE, 32'h0);
        rdx(`PMISR_OFF_STATE, 32'h1);
        rdx(7'h7f, 32'h0);
        for (n = 0; n < 4; n = n + 1) begin
            lfsr = nx(lfsr);
            vsample_in = lfsr;
            lfsr = nx(lfsr);
            isample_in = lfsr;
            sample_valid_in = 1'b1;
            wt(1);
            sample_valid_in = 1'b0;
            pr = $signed(vsample_in) * $signed(isample_in);
            pr = pr >>> `PMISR_FRAC;
            rdx(`PMISR_OFF_SAMPLE, {isample_in, vsample_in});
            rdx(`PMISR_OFF_POWER, {16'h0, pr[15:0]});
        end
        i2c_mode_in = 1'b1;
        oc_fault_in = 1'b1;
        wt(8);
        rdx(`PMISR_OFF_FLAGS, 32'h6);
        check({30'h0, pin0_out, pin1_out}, 32'h3);
        oc_fault_in = 1'b0;
        wt(8);
        rdx(`PMISR_OFF_FLAGS, 32'h4);
        check({30'h0, pin0_out, pin1_out}, 32'h1);
        u_host.xfer(1'b1, `PMISR_OFF_FLAGS, 32'h4);
        rdx(`PMISR_OFF_FLAGS, 32'h0);
        {zc_event_in, squarewave_en_in, ov_fault_in, uv_fault_in} = 4'hf;
        i2c_mode_in = 1'b0;
        wt(8);
        rdx(`PMISR_OFF_FLAGS, 32'h19);
        check({30'h0, pin0_out, pin1_out}, 32'h0);
        // A steady crossing level gives no pulse once the square wave mode is left.
        squarewave_en_in = 1'b0;
        halfcycle_en_in = 1'b1;
        pin0_sel_in = `PMISR_SEL_VOLT;
        pin1_sel_in = `PMISR_SEL_ZC;
        i2c_mode_in = 1'b1;
        wt(8);
        rdx(`PMISR_OFF_FLAGS, 32'h18);
        check({30'h0, pin0_out, pin1_out}, 32'h2);
        for (n = 0; n < 10 && expq.size() > 0; n = n + 1) wt(1);
        if (expq.size() > 0) check(32'h0, 32'h1);
        give_verdict;
    end
endmodule // tb_top
